// ---- logic/dfx_exec.sv ----
// decrement-file and decimal-adjust execution datapath with data memory
//
// Overview of operation
// RQ1: opcode 000001 decodes as decrement, result f minus one
// RQ2: destination bit zero writes accumulator, file untouched
// RQ3: destination bit one writes back same file
// RQ4: access bit one uses bank select for address
// RQ5: access zero, extended set, f<=95 is indexed
// RQ6: update carry, digit carry, sign, overflow, zero; one cycle
// RQ7: decimal adjust adds six per nibble, sets carry
`timescale 1ns/1ps
module dfx_exec
    import dfx_pkg::*;
(
    input  wire logic                    clk_i,
    input  wire logic                    resetn_i,
    input  wire logic                    instr_valid_i,
    input  wire logic [15:0]             instr_i,
    input  wire logic [3:0]              bank_sel_i,
    input  wire logic                    ext_set_en_i,
    input  wire logic [dfx_pkg::ADDR_W-1:0] index_base_i,
    input  wire logic                    load_en_i,
    input  wire logic [dfx_pkg::ADDR_W-1:0] load_addr_i,
    input  wire logic [7:0]              load_data_i,
    input  wire logic                    w_load_en_i,
    input  wire logic [7:0]              w_load_data_i,
    input  wire logic [dfx_pkg::ADDR_W-1:0] peek_addr_i,
    output logic      [7:0]              peek_data_o,
    output logic      [7:0]              acc_o,
    output logic                         carry_flag_o,
    output logic                         digit_carry_flag_o,
    output logic                         negative_flag_o,
    output logic                         overflow_flag_o,
    output logic                         zero_flag_o,
    output logic                         done_o
);
    import dfx_pkg::*;

    logic [7:0]        mem_q [MEM_DEPTH];
    logic [7:0]        w_q;
    logic              c_q;
    logic              dcy_q;
    logic              n_q;
    logic              ovf_q;
    logic              z_q;
    logic              done_q;
    logic [7:0]        peek_q;
    dfx_op_type        op;
    logic [ADDR_W-1:0] opnd_addr;
    logic [7:0]        opnd;
    logic [7:0]        dec_res;
    logic [8:0]        adj_sum;
    logic              adj_hi;

    function automatic logic needs_adj(input logic [3:0] nib, input logic flag);
        return (nib > BCD_MAX) || flag;
    endfunction

    function automatic logic [ADDR_W-1:0] calc_addr(input logic acc, input logic [7:0] f,
                                                     input logic [3:0] bank, input logic ext,
                                                     input logic [ADDR_W-1:0] base);
        logic [ADDR_W-1:0] a;
        a = {ACC_LO_BANK, f};
        if (acc) begin
            a = {bank, f}; // RQ4
        end else if (ext && (f <= IDX_LIMIT)) begin
            a = base + {4'h0, f}; // RQ5
        end else if (f > IDX_LIMIT) begin
            a = {ACC_HI_BANK, f};
        end
        return a;
    endfunction

    always_comb begin
        op = DFX_OP_NONE;
        if (instr_valid_i && (instr_i[OPC_HI_BIT:OPC_LO_BIT] == OPC_DEC_FILE)) begin
            op = DFX_OP_DEC_FILE; // RQ1
        end else if (instr_valid_i && (instr_i == OPC_DEC_ADJ)) begin
            op = DFX_OP_DEC_ADJ; // RQ7
        end
    end

    assign opnd_addr = calc_addr(instr_i[ACC_BIT], instr_i[7:0], bank_sel_i, ext_set_en_i, index_base_i);
    assign opnd      = mem_q[opnd_addr];
    assign dec_res   = opnd - 8'h01; // RQ1

    always_comb begin
        adj_sum = {1'b0, w_q};
        adj_hi  = needs_adj(w_q[7:4], c_q);
        if (needs_adj(w_q[3:0], dcy_q)) begin
            adj_sum = adj_sum + BCD_ADJ_LO; // RQ7
        end
        if (adj_hi) begin
            adj_sum = adj_sum + BCD_ADJ_HI; // RQ7
        end
    end

    always_ff @(posedge clk_i) begin
        if (load_en_i) begin
            mem_q[load_addr_i] <= load_data_i;
        end else if ((op == DFX_OP_DEC_FILE) && instr_i[DEST_BIT]) begin
            mem_q[opnd_addr] <= dec_res; // RQ3
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            w_q <= W_RESET;
        end else if (w_load_en_i) begin
            w_q <= w_load_data_i;
        end else if ((op == DFX_OP_DEC_FILE) && !instr_i[DEST_BIT]) begin
            w_q <= dec_res; // RQ2
        end else if (op == DFX_OP_DEC_ADJ) begin
            w_q <= adj_sum[7:0]; // RQ7
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            c_q   <= 1'b0;
            dcy_q <= 1'b0;
            n_q   <= 1'b0;
            ovf_q <= 1'b0;
            z_q   <= 1'b0;
        end else if (op == DFX_OP_DEC_FILE) begin
            c_q   <= (opnd != 8'h00); // RQ6
            dcy_q <= (opnd[3:0] != 4'h0); // RQ6
            n_q   <= dec_res[7]; // RQ6
            ovf_q <= (opnd == SIGN_ONLY); // RQ6
            z_q   <= (dec_res == 8'h00); // RQ6
        end else if ((op == DFX_OP_DEC_ADJ) && (adj_hi || adj_sum[8])) begin
            c_q <= 1'b1; // RQ7
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            done_q <= 1'b0;
            peek_q <= 8'h00;
        end else begin
            done_q <= (op != DFX_OP_NONE); // RQ6
            peek_q <= mem_q[peek_addr_i];
        end
    end

    assign peek_data_o        = peek_q;
    assign acc_o              = w_q;
    assign carry_flag_o       = c_q;
    assign digit_carry_flag_o = dcy_q;
    assign negative_flag_o    = n_q;
    assign overflow_flag_o    = ovf_q;
    assign zero_flag_o        = z_q;
    assign done_o             = done_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    dec_to_acc_a: assert property ((op == DFX_OP_DEC_FILE) && !instr_i[DEST_BIT] && !w_load_en_i // RQ2
        |=> w_q == $past(dec_res))
        else $error("decrement to accumulator wrong");
    dec_to_file_a: assert property ((op == DFX_OP_DEC_FILE) && instr_i[DEST_BIT] && !load_en_i // RQ3
        |=> (mem_q[$past(opnd_addr)] == $past(opnd) - 8'h01) && (w_q == $past(w_q) || $past(w_load_en_i)))
        else $error("decrement write-back wrong");
    dec_value_a: assert property ((op == DFX_OP_DEC_FILE) |-> dec_res + 8'h01 == opnd) // RQ1
        else $error("decrement result wrong");
    bank_addr_a: assert property (instr_valid_i && instr_i[ACC_BIT] // RQ4
        |-> opnd_addr == {bank_sel_i, instr_i[7:0]})
        else $error("banked address wrong");
    indexed_addr_a: assert property (!instr_i[ACC_BIT] && ext_set_en_i && (instr_i[7:0] <= IDX_LIMIT) // RQ5
        |-> opnd_addr == index_base_i + {4'h0, instr_i[7:0]})
        else $error("indexed address wrong");
    zero_flag_a: assert property ((op == DFX_OP_DEC_FILE) // RQ6
        |=> (z_q == ($past(opnd) == 8'h01)) && (c_q == ($past(opnd) != 8'h00)) && done_o)
        else $error("decrement flags or timing wrong");
    adj_carry_a: assert property ((op == DFX_OP_DEC_ADJ) && (w_q[7:4] > BCD_MAX) |=> c_q) // RQ7
        else $error("decimal adjust carry missing");

    neg_flag_a: assert property ((op == DFX_OP_DEC_FILE) // RQ6
        |=> n_q == $past(dec_res[7]))
        else $error("decrement sign flag wrong");
    ovf_flag_a: assert property ((op == DFX_OP_DEC_FILE) // RQ6
        |=> ovf_q == ($past(opnd) == SIGN_ONLY))
        else $error("decrement overflow flag wrong");
    dcy_flag_a: assert property ((op == DFX_OP_DEC_FILE) // RQ6
        |=> dcy_q == ($past(opnd[3:0]) != 4'h0))
        else $error("decrement digit carry flag wrong");
    done_pulse_a: assert property ((op == DFX_OP_NONE) // RQ6
        |=> !done_o)
        else $error("done without an instruction");
    file_keep_a: assert property ((op == DFX_OP_DEC_FILE) && !instr_i[DEST_BIT] && !load_en_i // RQ2
        |=> mem_q[$past(opnd_addr)] == $past(opnd))
        else $error("file changed by decrement to accumulator");
    unknown_op_a: assert property (instr_valid_i && (op == DFX_OP_NONE) && !w_load_en_i // RQ1
        |=> (w_q == $past(w_q)) && (c_q == $past(c_q)) && (z_q == $past(z_q)))
        else $error("unknown opcode changed state");

    load_win_a: assert property (load_en_i // RQ3
        |=> mem_q[$past(load_addr_i)] == $past(load_data_i))
        else $error("preload lost");
    acc_load_a: assert property (w_load_en_i // RQ2
        |=> w_q == $past(w_load_data_i))
        else $error("accumulator load lost");

    adj_keep_a: assert property ((op == DFX_OP_DEC_ADJ) && !w_load_en_i && !c_q && !dcy_q // RQ7
        && (w_q[3:0] <= BCD_MAX) && (w_q[7:4] <= BCD_MAX) |=> w_q == $past(w_q))
        else $error("decimal adjust changed valid value");
    adj_flags_a: assert property ((op == DFX_OP_DEC_ADJ) // RQ7
        |=> (dcy_q == $past(dcy_q)) && (n_q == $past(n_q)) && (ovf_q == $past(ovf_q)) && (z_q == $past(z_q)))
        else $error("decimal adjust touched other flags");

    dec_acc_c: cover property ((op == DFX_OP_DEC_FILE) && !instr_i[DEST_BIT]);
    dec_file_c: cover property ((op == DFX_OP_DEC_FILE) && instr_i[DEST_BIT] ##1 (op == DFX_OP_DEC_FILE));
    idx_c: cover property ((op == DFX_OP_DEC_FILE) && !instr_i[ACC_BIT] && ext_set_en_i && (instr_i[7:0] <= IDX_LIMIT));
    adj_c: cover property ((op == DFX_OP_DEC_ADJ) && (w_q == 8'hce));
    ovf_c: cover property ((op == DFX_OP_DEC_FILE) && (opnd == SIGN_ONLY));
endmodule

// ---- logic/dfx_pkg.sv ----
// constants for the decrement-file execution datapath
package dfx_pkg;
    localparam int unsigned ADDR_W        = 12;
    localparam int unsigned MEM_DEPTH     = 4096;
    localparam logic [5:0]  OPC_DEC_FILE  = 6'h01;
    localparam logic [15:0] OPC_DEC_ADJ   = 16'h0007;
    localparam int unsigned OPC_HI_BIT    = 15;
    localparam int unsigned OPC_LO_BIT    = 10;
    localparam int unsigned DEST_BIT      = 9;
    localparam int unsigned ACC_BIT       = 8;
    localparam logic [7:0]  IDX_LIMIT     = 8'h5f;
    localparam logic [3:0]  ACC_HI_BANK   = 4'hf;
    localparam logic [3:0]  ACC_LO_BANK   = 4'h0;
    localparam logic [3:0]  BCD_MAX       = 4'h9;
    localparam logic [8:0]  BCD_ADJ_LO    = 9'h006;
    localparam logic [8:0]  BCD_ADJ_HI    = 9'h060;
    localparam logic [7:0]  W_RESET       = 8'h00;
    localparam logic [7:0]  SIGN_ONLY     = 8'h80;
    localparam real         CLK_PERIOD_NS = 40.0;
    localparam int unsigned EXEC_CYCLES   = 1;

    typedef enum logic [1:0] {
        DFX_OP_NONE = 2'b00,
        DFX_OP_DEC_FILE = 2'b01,
        DFX_OP_DEC_ADJ  = 2'b10
    } dfx_op_type;
endpackage

// ---- testbench/tb_dfx_exec.sv ----
// self-checking bench for the decrement-file execution datapath
`timescale 1ns/1ps
module tb_dfx_exec;
    import dfx_pkg::*;
    logic              clk_i = 1'b0, resetn_i = 1'b0, instr_valid_i = 1'b0, ext_set_en_i = 1'b0;
    logic              load_en_i = 1'b0, w_load_en_i = 1'b0;
    logic [15:0]       instr_i = '0;
    logic [3:0]        bank_sel_i = '0;
    logic [ADDR_W-1:0] index_base_i = '0, load_addr_i = '0, peek_addr_i = '0;
    logic [7:0]        load_data_i = '0, w_load_data_i = '0, peek_data_o, acc_o, m_acc, res, op;
    logic              carry_flag_o, digit_carry_flag_o, negative_flag_o, overflow_flag_o, zero_flag_o, done_o;
    logic              m_c = 1'b0, m_dcy = 1'b0, m_n = 1'b0, m_ovf = 1'b0, m_z = 1'b0;
    logic [7:0]        edge_v [4] = '{8'h00, 8'h80, 8'h01, 8'h10};
    int                mismatches = 0, comparisons = 0, seed = 32;
    wire logic [7:0]   st = {2'h0, carry_flag_o, digit_carry_flag_o, negative_flag_o, overflow_flag_o,
                             zero_flag_o, done_o};
    always #20 clk_i = ~clk_i;
    dfx_exec u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
        .bank_sel_i(bank_sel_i), .ext_set_en_i(ext_set_en_i), .index_base_i(index_base_i),
        .load_en_i(load_en_i), .load_addr_i(load_addr_i), .load_data_i(load_data_i),
        .w_load_en_i(w_load_en_i), .w_load_data_i(w_load_data_i), .peek_addr_i(peek_addr_i),
        .peek_data_o(peek_data_o), .acc_o(acc_o), .carry_flag_o(carry_flag_o),
        .digit_carry_flag_o(digit_carry_flag_o), .negative_flag_o(negative_flag_o),
        .overflow_flag_o(overflow_flag_o), .zero_flag_o(zero_flag_o), .done_o(done_o));
    task chk(input logic [7:0] got, input logic [7:0] exp, input string s);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask
    // preload the operand, run one decrement, check result, flags and memory
    task run(input logic [15:0] ins, input int i);
        logic [ADDR_W-1:0] ad;
        ad = ins[8] ? {bank_sel_i, ins[7:0]} : (ins[7:0] <= IDX_LIMIT ? (ext_set_en_i ?
             index_base_i + ins[7:0] : {4'h0, ins[7:0]}) : {4'hf, ins[7:0]});
        op = i < 4 ? edge_v[i] : 8'($random(seed));
        load_en_i = 1'b1; load_addr_i = ad; load_data_i = op;
        @(negedge clk_i);
        load_en_i = 1'b0; instr_valid_i = 1'b1; instr_i = ins;
        res = op - 8'h01;
        m_c = op != 8'h00; m_dcy = op[3:0] != 4'h0; m_n = res[7]; m_ovf = op == 8'h80; m_z = res == 8'h00;
        if (!ins[DEST_BIT]) m_acc = res;
        @(negedge clk_i);
        instr_valid_i = 1'b0; peek_addr_i = ad;
        chk(acc_o, m_acc, "accumulator after decrement");
        chk(st, {2'h0, m_c, m_dcy, m_n, m_ovf, m_z, 1'b1}, "flags after decrement");
        @(negedge clk_i);
        chk(peek_data_o, ins[DEST_BIT] ? res : op, "file after decrement");
    endtask
    task adj(input logic [7:0] w);
        w_load_en_i = 1'b1; w_load_data_i = w;
        @(negedge clk_i);
        w_load_en_i = 1'b0; instr_valid_i = 1'b1; instr_i = OPC_DEC_ADJ;
        m_acc = w + ((w[3:0] > 4'h9 || m_dcy) ? 8'h06 : 8'h00) + ((w[7:4] > 4'h9 || m_c) ? 8'h60 : 8'h00);
        m_c = m_c | w[7:4] > 4'h9;
        @(negedge clk_i);
        instr_valid_i = 1'b0;
        chk(acc_o, m_acc, "accumulator after adjust");
        chk(st, {2'h0, m_c, m_dcy, m_n, m_ovf, m_z, 1'b1}, "flags after adjust");
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        m_acc = W_RESET;
        repeat (5) @(negedge clk_i);
        resetn_i = 1'b1;
        chk(st, 8'h00, "flags after reset");
        chk(acc_o, W_RESET, "accumulator after reset");
        $display("test reset done");
        adj(8'ha5);
        adj(8'hce);
        for (int i = 0; i < 200; i++) begin
            bank_sel_i = 4'($random(seed));
            ext_set_en_i = 1'($random(seed));
            index_base_i = 12'($random(seed));
            if (i % 5 == 4) adj(8'($random(seed)));
            else run({OPC_DEC_FILE, 2'($random(seed)), 8'($random(seed))}, i);
        end
        $display("test decrement and adjust done");
        instr_valid_i = 1'b1; instr_i = 16'hffff;
        @(negedge clk_i);
        instr_valid_i = 1'b0;
        chk(acc_o, m_acc, "accumulator after unknown opcode");
        chk(st, {2'h0, m_c, m_dcy, m_n, m_ovf, m_z, 1'b0}, "done after unknown opcode");
        $display("test unknown opcode done");
        print_verdict;
    end
endmodule
